// file: shared/crf_map.svh
// Register map, field positions and reset values of the CPU register file
`ifndef CRF_MAP_SVH
`define CRF_MAP_SVH
`define CRF_NUM_REGS      32
`define CRF_PTR_X_LO      5'h1a
`define CRF_PTR_Y_LO      5'h1c
`define CRF_PTR_Z_LO      5'h1e
`define CRF_IO_BASE       8'h20
`define CRF_IO_LAST       8'h5f
`define CRF_EXT_BASE      8'h60
`define CRF_EXT_LAST      8'hff
`define CRF_FLAG_I        7
`define CRF_FLAG_T        6
`define CRF_FLAG_H        5
`define CRF_FLAG_S        4
`define CRF_FLAG_V        3
`define CRF_FLAG_N        2
`define CRF_FLAG_Z        1
`define CRF_FLAG_C        0
`define CRF_FLAGS_RESET   8'h00
`define CRF_OFS_FLAGS     32'h0000_0000
`define CRF_OFS_GPR_BASE  32'h0000_0100
`define CRF_OFS_GPR_LAST  32'h0000_017c
`endif

// file: shared/crf_pkg.sv
// Types shared by the CPU register file and its users
package crf_pkg;
    typedef enum logic [3:0] {
        CRF_OP_NONE, CRF_OP_ADD, CRF_OP_ADC, CRF_OP_SUB, CRF_OP_SBC,
        CRF_OP_AND, CRF_OP_OR, CRF_OP_EOR, CRF_OP_MOV, CRF_OP_COM,
        CRF_OP_NEG, CRF_OP_INC, CRF_OP_DEC, CRF_OP_LSR, CRF_OP_ADIW, CRF_OP_SBIW
    } crf_op_t;

    typedef enum logic [1:0] {
        CRF_SPC_REG, CRF_SPC_IO, CRF_SPC_EXT, CRF_SPC_SRAM
    } crf_space_t;

    // One decoded instruction from the decode logic
    typedef struct packed {
        logic       valid;
        crf_op_t    op;
        logic [4:0] rd;
        logic [4:0] rr;
        logic       use_imm;
        logic [7:0] imm;
        logic       bit_store;
        logic       bit_load;
        logic [2:0] bit_sel;
        logic       irq_taken;
        logic       irq_return;
        logic       irq_set;
        logic       irq_clr;
    } crf_instr_t;

    // Data-space request from the load/store path
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        io_direct;
        logic [1:0]  ptr_sel;
        logic [5:0]  disp;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } crf_mem_t;
endpackage

// file: core/crf_core.sv
// CPU register file, ALU and status flags with an AXI4-Lite debug view
//
// What this block does
// - Thirty-two 8-bit registers, each read or written in one cycle.
// - Two operands read, computed and written back in the same cycle.
// - Ports: 8r/8w, two 8r/8w, 16r/16w.
// - Registers 0x1A..0x1F form three 16-bit pointers, low byte even.
// - The third pointer also addresses program flash tables.
// - Data addresses below 32 hit the working registers, not SRAM.
// - 64 I/O addresses, direct or at data addresses 0x20..0x5F.
// - Extended I/O 0x60..0xFF reached only by data load and store.
// - ALU works reg-reg, reg-immediate or single register in one cycle.
// - Flags updated after every ALU operation except MOV.
// - Bit 7 is the global interrupt enable gating all interrupts.
// - Enable cleared on interrupt entry, set on return, set/clear instructions.
// - Bit 6 is the copy bit for bit store and bit load.
// - Bit 5 is the half carry out of the low nibble.
// - Bit 4 always equals negative xor overflow.
// - Bit 3 is two's complement overflow.
// - Bit 2 is set on a negative result.
// - Bit 1 is set on a zero result.
// - Bit 0 records carry.
// - Flags are neither saved on interrupt entry nor restored on return.
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "crf_map.svh"

module crf_core
    import crf_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire crf_instr_t  instr,
    input  wire crf_mem_t    mem_req,
    input  wire logic        irq_pending,
    output logic [7:0]       op_a,
    output logic [7:0]       op_b,
    output logic [7:0]       cpu_status_flags,
    output logic             irq_accept,
    output logic [15:0]      mem_addr,
    output crf_space_t       mem_space,
    output logic             mem_strobe,
    output logic             mem_write,
    output logic [7:0]       mem_wdata,
    output logic [7:0]       mem_reg_rdata,
    output logic [15:0]      flash_table_addr,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    logic [7:0]  gpr_r [`CRF_NUM_REGS];
    logic [7:0]  flags_r;
    logic [7:0]  flags_nxt;
    logic [7:0]  ra;
    logic [7:0]  rb;
    logic [7:0]  res;
    logic [15:0] wres;
    logic        wide;
    logic        wr_en;
    logic [15:0] ptr_val;
    logic [15:0] eff_addr;
    crf_space_t  space;
    logic        reg_hit;
    logic        aw_hold_r;
    logic        w_hold_r;
    logic [31:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        dbg_wr;
    logic [4:0]  dbg_idx;

    function automatic logic [15:0] pair(input logic [4:0] lo);
        pair = {gpr_r[lo | 5'h01], gpr_r[lo & 5'h1e]};
    endfunction

    function automatic logic gpr_hit(input logic [31:0] a);
        gpr_hit = a >= `CRF_OFS_GPR_BASE && a <= `CRF_OFS_GPR_LAST && a[1:0] == 2'b00;
    endfunction

    function automatic crf_space_t classify(input logic [15:0] a, input logic io);
        if (io)
            classify = CRF_SPC_IO;
        else if (a < 16'h0020)
            classify = CRF_SPC_REG;
        else if (a <= {8'h00, `CRF_IO_LAST})
            classify = CRF_SPC_IO;
        else if (a <= {8'h00, `CRF_EXT_LAST})
            classify = CRF_SPC_EXT;
        else
            classify = CRF_SPC_SRAM;
    endfunction

    // Operand read is purely combinational so the ALU result lands the same cycle
    assign ra = gpr_r[instr.rd];
    assign rb = instr.use_imm ? instr.imm : gpr_r[instr.rr];

    // ALU and flag generation
    always_comb
    begin
        logic [8:0]  sum;
        logic [16:0] w;
        logic        c;
        logic        h;
        logic        v;
        logic        n;
        logic        logic_op;
        sum = 9'h000;
        w = 17'h00000;
        c = flags_r[`CRF_FLAG_C];
        h = flags_r[`CRF_FLAG_H];
        v = flags_r[`CRF_FLAG_V];
        logic_op = 1'b0;
        wide = 1'b0;
        wr_en = instr.valid && instr.op != CRF_OP_NONE;
        res = ra;
        case (instr.op)
            CRF_OP_ADD, CRF_OP_ADC:
            begin
                sum = {1'b0, ra} + {1'b0, rb}
                    + {8'h00, instr.op == CRF_OP_ADC && flags_r[`CRF_FLAG_C]};
                res = sum[7:0];
                c = sum[8];
                h = (ra[3] & rb[3]) | (rb[3] & ~res[3]) | (~res[3] & ra[3]);
                v = (ra[7] & rb[7] & ~res[7]) | (~ra[7] & ~rb[7] & res[7]);
            end
            CRF_OP_SUB, CRF_OP_SBC:
            begin
                sum = {1'b0, ra} - {1'b0, rb}
                    - {8'h00, instr.op == CRF_OP_SBC && flags_r[`CRF_FLAG_C]};
                res = sum[7:0];
                c = sum[8];
                h = (~ra[3] & rb[3]) | (rb[3] & res[3]) | (res[3] & ~ra[3]);
                v = (ra[7] & ~rb[7] & ~res[7]) | (~ra[7] & rb[7] & res[7]);
            end
            CRF_OP_AND:
            begin
                res = ra & rb;
                logic_op = 1'b1;
            end
            CRF_OP_OR:
            begin
                res = ra | rb;
                logic_op = 1'b1;
            end
            CRF_OP_EOR:
            begin
                res = ra ^ rb;
                logic_op = 1'b1;
            end
            CRF_OP_MOV:
                res = rb;
            CRF_OP_COM:
            begin
                res = ~ra;
                c = 1'b1;
                logic_op = 1'b1;
            end
            CRF_OP_NEG:
            begin
                res = 8'h00 - ra;
                c = res != 8'h00;
                h = res[3] | ra[3];
                v = res == 8'h80;
            end
            CRF_OP_INC:
            begin
                res = ra + 8'h01;
                v = res == 8'h80;
            end
            CRF_OP_DEC:
            begin
                res = ra - 8'h01;
                v = res == 8'h7f;
            end
            CRF_OP_LSR:
            begin
                res = {1'b0, ra[7:1]};
                c = ra[0];
                v = ra[0];
            end
            CRF_OP_ADIW, CRF_OP_SBIW:
            begin
                // Word op reads one pair and writes it back as one 16-bit result
                wide = 1'b1;
                w = (instr.op == CRF_OP_ADIW)
                    ? {1'b0, pair(instr.rd)} + {9'h000, instr.imm}
                    : {1'b0, pair(instr.rd)} - {9'h000, instr.imm};
                c = w[16];
                v = (instr.op == CRF_OP_ADIW) ? (~gpr_r[instr.rd | 5'h01][7] & w[15])
                                              : (gpr_r[instr.rd | 5'h01][7] & ~w[15]);
                res = w[7:0];
            end
            default:
                wr_en = 1'b0;
        endcase
        if (logic_op)
            v = 1'b0;
        wres = w[15:0];
        n = wide ? wres[15] : res[7];
        flags_nxt = flags_r;
        if (wr_en && instr.op != CRF_OP_MOV)
        begin
            flags_nxt[`CRF_FLAG_C] = c;
            flags_nxt[`CRF_FLAG_Z] = wide ? (wres == 16'h0000) : (res == 8'h00);
            flags_nxt[`CRF_FLAG_N] = n;
            flags_nxt[`CRF_FLAG_V] = v;
            flags_nxt[`CRF_FLAG_S] = n ^ v;
            flags_nxt[`CRF_FLAG_H] = h;
        end
        if (instr.valid && instr.bit_store)
            flags_nxt[`CRF_FLAG_T] = ra[instr.bit_sel];
        // Entry and return touch only the enable bit; software keeps the rest
        if (instr.valid && (instr.irq_return || instr.irq_set))
            flags_nxt[`CRF_FLAG_I] = 1'b1;
        if (instr.valid && instr.irq_clr)
            flags_nxt[`CRF_FLAG_I] = 1'b0;
        if (irq_pending && flags_r[`CRF_FLAG_I])
            flags_nxt[`CRF_FLAG_I] = 1'b0;
        if (dbg_wr && aw_addr_r == `CRF_OFS_FLAGS && w_strb_r[0])
            flags_nxt = {w_data_r[7:5], w_data_r[2] ^ w_data_r[3], w_data_r[3:0]};
    end

    // Pointer based data-space addressing
    always_comb
    begin
        ptr_val = pair(`CRF_PTR_X_LO + {mem_req.ptr_sel, 1'b0});
        eff_addr = (mem_req.ptr_sel == 2'b11) ? mem_req.addr
                                              : ptr_val + {10'h000, mem_req.disp};
        if (mem_req.io_direct)
            eff_addr = {10'h000, mem_req.addr[5:0]} + {8'h00, `CRF_IO_BASE};
        space = classify(eff_addr, mem_req.io_direct);
        reg_hit = mem_req.valid && space == CRF_SPC_REG;
    end

    // Register array write port; AXI debug writes have lowest priority
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < `CRF_NUM_REGS; i++)
                gpr_r[i] <= 8'h00;
        end
        else if (wr_en && wide)
        begin
            gpr_r[instr.rd & 5'h1e] <= wres[7:0];
            gpr_r[instr.rd | 5'h01] <= wres[15:8];
        end
        else if (wr_en)
            gpr_r[instr.rd] <= res;
        else if (instr.valid && instr.bit_load)
            gpr_r[instr.rd][instr.bit_sel] <= flags_r[`CRF_FLAG_T];
        else if (reg_hit && mem_req.write)
            gpr_r[eff_addr[4:0]] <= mem_req.wdata;
        else if (dbg_wr && gpr_hit(aw_addr_r) && w_strb_r[0])
            gpr_r[dbg_idx] <= w_data_r[7:0];
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            flags_r <= `CRF_FLAGS_RESET;
        else
            flags_r <= flags_nxt;
    end

    // Registered outputs to the ALU, decode and memory paths
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            op_a <= 8'h00;
            op_b <= 8'h00;
            cpu_status_flags <= `CRF_FLAGS_RESET;
            irq_accept <= 1'b0;
            mem_addr <= 16'h0000;
            mem_space <= CRF_SPC_REG;
            mem_strobe <= 1'b0;
            mem_write <= 1'b0;
            mem_wdata <= 8'h00;
            mem_reg_rdata <= 8'h00;
            flash_table_addr <= 16'h0000;
        end
        else
        begin
            op_a <= ra;
            op_b <= rb;
            cpu_status_flags <= flags_nxt;
            irq_accept <= irq_pending && flags_r[`CRF_FLAG_I];
            mem_addr <= eff_addr;
            mem_space <= space;
            // Register hits never reach the memory bus: no SRAM backs them
            mem_strobe <= mem_req.valid && space != CRF_SPC_REG;
            mem_write <= mem_req.write;
            mem_wdata <= mem_req.wdata;
            mem_reg_rdata <= gpr_r[eff_addr[4:0]];
            flash_table_addr <= pair(`CRF_PTR_Z_LO);
        end
    end

    // AXI4-Lite slave: flags at 0x000, registers at 0x100 + 4*n
    assign dbg_wr = aw_hold_r && w_hold_r && !s_axi_bvalid;
    assign dbg_idx = aw_addr_r[6:2];

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            aw_addr_r <= 32'h0000_0000;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (dbg_wr)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_r == `CRF_OFS_FLAGS || gpr_hit(aw_addr_r))
                    ? 2'b00 : 2'b10;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            if (s_axi_araddr == `CRF_OFS_FLAGS)
            begin
                s_axi_rdata <= {24'h000000, flags_r};
                s_axi_rresp <= 2'b00;
            end
            else if (gpr_hit(s_axi_araddr))
            begin
                s_axi_rdata <= {24'h000000, gpr_r[s_axi_araddr[6:2]]};
                s_axi_rresp <= 2'b00;
            end
            else
            begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= 2'b10;
            end
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    a_sign_is_xor: assert property (@(posedge ref_clk) disable iff (!arst_n)
        flags_r[`CRF_FLAG_S] == (flags_r[`CRF_FLAG_N] ^ flags_r[`CRF_FLAG_V]))
        else $error("sign flag differs from N xor V");

    a_zero_flag_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wr_en && !wide && instr.op != CRF_OP_MOV && res == 8'h00 && !dbg_wr
        |=> flags_r[`CRF_FLAG_Z])
        else $error("zero result did not set Z");

    a_neg_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wr_en && !wide && instr.op != CRF_OP_MOV && !dbg_wr
        |=> flags_r[`CRF_FLAG_N] == $past(res[7]))
        else $error("N does not follow result bit 7");

    a_reg_writeback: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wr_en && !wide |=> gpr_r[$past(instr.rd)] == $past(res))
        else $error("ALU result not written back in one cycle");

    a_irq_gate: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !flags_r[`CRF_FLAG_I] |=> !irq_accept)
        else $error("interrupt taken while globally disabled");

    a_irq_entry_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
        irq_pending && flags_r[`CRF_FLAG_I] && !dbg_wr |=> !flags_r[`CRF_FLAG_I])
        else $error("enable not cleared on interrupt entry");

    a_copy_bit_store: assert property (@(posedge ref_clk) disable iff (!arst_n)
        instr.valid && instr.bit_store && !dbg_wr
        |=> flags_r[`CRF_FLAG_T] == $past(ra[instr.bit_sel]))
        else $error("copy bit not stored");

    a_reg_no_sram: assert property (@(posedge ref_clk) disable iff (!arst_n)
        mem_req.valid && !mem_req.io_direct && eff_addr < 16'h0020 |=> !mem_strobe)
        else $error("register address reached the memory bus");

endmodule
`default_nettype wire

// file: testbench/crf_dec_model.sv
// Decode-side model that issues one instruction and one data request per command
`timescale 1ns/100ps
`default_nettype none
module crf_dec_model
    import crf_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    input  wire crf_instr_t cmd_instr,
    input  wire crf_mem_t   cmd_mem,
    output crf_instr_t      instr,
    output crf_mem_t        mem_req
);
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            instr <= '0;
        else
            instr <= cmd_instr;
    end
    // Released address and data lines toggle so a stale value never looks valid
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            mem_req <= '0;
        else if (cmd_mem.valid)
        begin
            mem_req <= cmd_mem;
            if (cmd_mem.io_direct)
                mem_req.addr <= {10'h000, cmd_mem.addr[5:0]};
        end
        else
            mem_req <= {3'h0, ~mem_req[31:0]};
    end
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench: bus access, ALU flags, pointers, spaces and interrupt enable
`timescale 1ns/100ps
`default_nettype none
`include "crf_map.svh"
module tb
    import crf_pkg::*;
();
    logic        ref_clk = 1'h0;
    logic        arst_n = 1'h0;
    logic        irq_pending = 1'h0;
    crf_instr_t  cmd_i = '0;
    crf_mem_t    cmd_m = '0;
    crf_instr_t  instr;
    crf_mem_t    mem_req;
    logic [7:0]  op_a, op_b, flags, mrd, mem_wdata, fl;
    logic        irq_accept, mem_strobe, mem_write;
    logic [15:0] mem_addr, fta;
    crf_space_t  mem_space;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [7:0]  rf [32];
    int          n_errors = 0;
    int          cmp_count = 0;
    crf_op_t     ops [6] = '{CRF_OP_ADD, CRF_OP_ADC, CRF_OP_SUB, CRF_OP_AND, CRF_OP_OR, CRF_OP_EOR};
    logic [15:0] adrs [5] = '{16'h0020, 16'h005f, 16'h0060, 16'h00ff, 16'h0100};
    crf_space_t  spcs [5] = '{CRF_SPC_IO, CRF_SPC_IO, CRF_SPC_EXT, CRF_SPC_EXT, CRF_SPC_SRAM};

    always #10 ref_clk = ~ref_clk;

    crf_dec_model u_dec (.ref_clk(ref_clk), .arst_n(arst_n), .cmd_instr(cmd_i),
        .cmd_mem(cmd_m), .instr(instr), .mem_req(mem_req));
    crf_core dut (.ref_clk(ref_clk), .arst_n(arst_n), .instr(instr), .mem_req(mem_req),
        .irq_pending(irq_pending), .op_a(op_a), .op_b(op_b), .cpu_status_flags(flags),
        .irq_accept(irq_accept), .mem_addr(mem_addr), .mem_space(mem_space),
        .mem_strobe(mem_strobe), .mem_write(mem_write), .mem_wdata(mem_wdata),
        .mem_reg_rdata(mrd), .flash_table_addr(fta), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (n_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic tmo(input int n);
        if (n >= 40)
        begin
            n_errors++;
            complete_run();
        end
    endtask

    // Each bus task starts on a fresh edge so no strobe is assigned twice in one step
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge ref_clk);
            n++;
            if (awready === 1'h1)
                awvalid <= 1'h0;
            if (wready === 1'h1)
                wvalid <= 1'h0;
        end
        while (bvalid !== 1'h1 && n < 40);
        tmo(n);
        r = bresp;
        bready <= 1'h0;
    endtask

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge ref_clk);
            n++;
            if (arready === 1'h1)
                arvalid <= 1'h0;
        end
        while (rvalid !== 1'h1 && n < 40);
        tmo(n);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask

    function automatic logic [31:0] gpr(input logic [4:0] k);
        return `CRF_OFS_GPR_BASE + {25'h0, k, 2'h0};
    endfunction

    task automatic wreg(input logic [4:0] k, input logic [7:0] v);
        logic [1:0] r;
        rf[k] = v;
        axi_wr(gpr(k), {24'h0, v}, r);
        chk(r, 2'h0);
    endtask

    // Model decodes at one edge, core acts at the next; outputs are read just after
    task automatic exec(input crf_instr_t i, input crf_mem_t m);
        @(posedge ref_clk);
        cmd_i <= i;
        cmd_m <= m;
        @(posedge ref_clk);
        cmd_i <= '0;
        cmd_m <= '0;
        @(posedge ref_clk);
        #1;
    endtask

    // Logic operations keep carry and half carry and clear overflow
    function automatic logic [15:0] alu(crf_op_t op, logic [7:0] a, b, f);
        logic [8:0] s;
        logic [4:0] n;
        logic [7:0] r;
        logic       ci, sb, lg, v;
        ci = (op == CRF_OP_ADC) & f[0];
        sb = op == CRF_OP_SUB;
        lg = !(op inside {CRF_OP_ADD, CRF_OP_ADC, CRF_OP_SUB});
        s = sb ? {1'h0, a} - {1'h0, b} : {1'h0, a} + {1'h0, b} + ci;
        n = sb ? {1'h0, a[3:0]} - {1'h0, b[3:0]} : {1'h0, a[3:0]} + {1'h0, b[3:0]} + ci;
        v = !lg && ((a[7] ^ b[7]) == sb) && (s[7] != a[7]);
        r = op == CRF_OP_AND ? a & b : op == CRF_OP_OR ? a | b : op == CRF_OP_EOR ? a ^ b : s[7:0];
        return {f[7:6], lg ? f[5] : n[4], r[7] ^ v, v, r[7], r == 8'h00, lg ? f[0] : s[8], r};
    endfunction

    initial
    begin
        logic [1:0]  rs;
        logic [31:0] d;
        logic [7:0]  a, b;
        logic [15:0] e;
        crf_instr_t  i;
        crf_mem_t    m;
        void'($urandom(1));
        fl = 8'h00;
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'h1;
        #1;
        chk(flags, 8'h00);
        axi_rd(`CRF_OFS_FLAGS, d, rs);
        chk(d, 32'h0);
        for (int k = 0; k < 32; k++)
            wreg(5'(k), 8'($urandom));
        wreg(5'h01, 8'hff);
        wreg(5'h02, 8'h01);
        for (int t = 0; t < 24; t++)
        begin
            i = '0;
            i.valid = 1'h1;
            i.op = t == 0 ? CRF_OP_ADD : ops[$urandom % 6];
            i.rd = t == 0 ? 5'h01 : 5'($urandom);
            i.rr = t == 0 ? 5'h02 : 5'($urandom);
            i.use_imm = t > 0 && 1'($urandom);
            i.imm = 8'($urandom);
            a = rf[i.rd];
            b = i.use_imm ? i.imm : rf[i.rr];
            e = alu(i.op, a, b, fl);
            exec(i, '0);
            rf[i.rd] = e[7:0];
            fl = e[15:8];
            chk(flags, fl);
            chk(op_a, a);
            chk(op_b, b);
            axi_rd(gpr(i.rd), d, rs);
            chk(d, {24'h0, rf[i.rd]});
        end
        for (int t = 0; t < 4; t++)
        begin
            i = '0;
            i.valid = 1'h1;
            i.bit_store = !t[0];
            i.bit_load = t[0];
            i.rd = 5'($urandom);
            i.bit_sel = 3'($urandom);
            exec(i, '0);
            if (i.bit_store)
                fl[6] = rf[i.rd][i.bit_sel];
            else
                rf[i.rd][i.bit_sel] = fl[6];
            chk(flags, fl);
            axi_rd(gpr(i.rd), d, rs);
            chk(d, {24'h0, rf[i.rd]});
        end
        i = '0;
        i.valid = 1'h1;
        i.op = CRF_OP_ADIW;
        i.rd = 5'h18;
        i.imm = 8'h3f;
        a = rf[25];
        e = {rf[25], rf[24]} + 16'h003f;
        exec(i, '0);
        {rf[25], rf[24]} = e;
        fl[4:0] = {a[7] & e[15], !a[7] & e[15], e[15], e == 16'h0000, e < 16'h003f};
        chk(flags, fl);
        i = '0;
        i.valid = 1'h1;
        i.irq_set = 1'h1;
        exec(i, '0);
        fl[7] = 1'h1;
        chk(flags, fl);
        @(posedge ref_clk);
        irq_pending <= 1'h1;
        @(posedge ref_clk);
        irq_pending <= 1'h0;
        #1;
        chk(irq_accept, 1'h1);
        repeat (2) @(posedge ref_clk);
        #1;
        fl[7] = 1'h0;
        chk(flags, fl);
        @(posedge ref_clk);
        irq_pending <= 1'h1;
        repeat (3)
        begin
            @(posedge ref_clk);
            #1;
            chk(irq_accept, 1'h0);
        end
        @(posedge ref_clk);
        irq_pending <= 1'h0;
        i.irq_set = 1'h0;
        i.irq_return = 1'h1;
        exec(i, '0);
        fl[7] = 1'h1;
        chk(flags, fl);
        i.irq_return = 1'h0;
        i.irq_clr = 1'h1;
        exec(i, '0);
        fl[7] = 1'h0;
        chk(flags, fl);
        wreg(5'h1a, 8'($urandom % 26));
        wreg(5'h1b, 8'h00);
        wreg(5'h1c, 8'($urandom % 26));
        wreg(5'h1d, 8'h00);
        m = '0;
        m.valid = 1'h1;
        exec('0, m);
        chk(mem_addr, {8'h00, rf[26]});
        chk(mem_space, CRF_SPC_REG);
        chk(mem_strobe, 1'h0);
        chk(mrd, rf[rf[26]]);
        m.write = 1'h1;
        m.ptr_sel = 2'h1;
        m.wdata = 8'($urandom);
        exec('0, m);
        rf[rf[28]] = m.wdata;
        chk(mem_addr, {8'h00, rf[28]});
        chk(mem_write, 1'h1);
        chk(mem_wdata, m.wdata);
        m.write = 1'h0;
        m.ptr_sel = 2'h2;
        exec('0, m);
        chk(mem_addr, {rf[31], rf[30]});
        for (int t = 0; t < 5; t++)
        begin
            m.ptr_sel = 2'h3;
            m.addr = adrs[t];
            exec('0, m);
            chk(mem_addr, adrs[t]);
            chk(mem_space, spcs[t]);
            chk(mem_strobe, 1'h1);
        end
        m.io_direct = 1'h1;
        m.addr = 16'h003f;
        exec('0, m);
        chk(mem_space, CRF_SPC_IO);
        chk(mem_addr, 16'h005f);
        axi_wr(32'h0000_0200, 32'h0000_00ff, rs);
        chk(rs, 2'h2);
        axi_rd(32'h0000_0204, d, rs);
        chk(rs, 2'h2);
        axi_rd(`CRF_OFS_FLAGS, d, rs);
        chk(d, {24'h0, fl});
        for (int k = 0; k < 32; k++)
        begin
            axi_rd(gpr(5'(k)), d, rs);
            chk(d, {24'h0, rf[k]});
        end
        chk(fta, {rf[31], rf[30]});
        complete_run();
    end
endmodule
`default_nettype wire
